// >>> src/modbus_slave_map.vh
`ifndef MODBUS_SLAVE_MAP_VH
`define MODBUS_SLAVE_MAP_VH

// Function codes
`define FC_READ_COILS     8'h01
`define FC_READ_DISCRETE  8'h02
`define FC_READ_HOLDING   8'h03
`define FC_READ_INPUT     8'h04
`define FC_WRITE_COIL     8'h05
`define FC_WRITE_REG      8'h06
`define FC_DIAG           8'h08
`define FC_WRITE_COILS    8'h0f
`define FC_WRITE_REGS     8'h10
`define FC_REPORT_ID      8'h11

// Diagnostic subfunction that returns the query data
`define DIAG_SUB_ECHO     16'h0000

// Exception codes and the flag bit set in the echoed function code
`define EXC_NONE          8'h00
`define EXC_FUNCTION      8'h01
`define EXC_ADDRESS       8'h02
`define EXC_VALUE         8'h03
`define EXC_READ_ONLY     8'h04
`define EXC_FLAG          8'h80

// Register map: parameter start addresses, in 16-bit register units
`define OFS_ONE_RATE      16'h0000
`define OFS_ONE_TOTAL     16'h0002
`define OFS_ONE_PRECISE   16'h0004
`define OFS_TWO_RATE      16'h0008
`define OFS_TWO_TOTAL     16'h000a
`define OFS_TWO_PRECISE   16'h000c
`define OFS_QUAD_RATE     16'h0010
`define OFS_QUAD_TOTAL    16'h0012
`define OFS_QUAD_PRECISE  16'h0014
`define MAP_WORDS         17'h00018
`define FLOAT_WORDS       3'h2
`define DOUBLE_WORDS      3'h4

// Quantity limits and fixed request lengths (bytes, function code included)
`define MAX_READ_REGS     16'h007d
`define MAX_WRITE_REGS    16'h007b
`define MAX_READ_BITS     16'h07d0
`define LEN_FIXED         9'h005
`define LEN_MULTI_HEAD    9'h006
`define LEN_DIAG_MIN      9'h003
`define LEN_REPORT_ID     9'h001
`define LEN_LIMIT         9'h100
`define COIL_ON           16'hff00
`define COIL_OFF          16'h0000
`define ID_BYTE_COUNT     8'h02
`define RUN_ON            8'hff

`endif

// >>> src/pdu_buffer.v
`timescale 1ns/10ps
`default_nettype none

module pdu_buffer (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire       wr_en_i,
  input  wire [7:0] wr_addr_i,
  input  wire [7:0] wr_data_i,
  input  wire [7:0] rd_addr_i,
  output reg  [7:0] rd_data_o
);

  reg [7:0] mem [0:255];

  // Storage has no reset; only the read register is cleared
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule // pdu_buffer

`default_nettype wire

// >>> src/flow_word_map.v
`timescale 1ns/10ps
`default_nettype none

module flow_word_map (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire        snap_i,
  input  wire [31:0] channel_one_rate_i,
  input  wire [31:0] channel_one_total_i,
  input  wire [63:0] channel_one_precise_total_i,
  input  wire [31:0] channel_two_rate_i,
  input  wire [31:0] channel_two_total_i,
  input  wire [63:0] channel_two_precise_total_i,
  input  wire [31:0] quadrature_rate_i,
  input  wire [31:0] quadrature_total_i,
  input  wire [63:0] quadrature_precise_total_i,
  input  wire [4:0]  addr_i,
  output reg  [15:0] word_o
);

  // One snapshot per request, so a multi-word value is never torn
  // between its halves while the measurement path updates it
  reg  [383:0] snap_reg;
  wire [8:0]   bit_top;

  // Word 0 sits in the top 16 bits; high word first within each value
  assign bit_top = 9'd383 - {addr_i, 4'h0};

  // Snapshot and registered read
  always @(posedge clock_i) begin
    if (rst_i) begin
      snap_reg <= 384'h0;
      word_o   <= 16'h0000;
    end else begin
      if (snap_i) begin
        snap_reg <= {channel_one_rate_i, channel_one_total_i, channel_one_precise_total_i,
                     channel_two_rate_i, channel_two_total_i, channel_two_precise_total_i,
                     quadrature_rate_i, quadrature_total_i, quadrature_precise_total_i};
      end
      word_o <= snap_reg[bit_top -: 16];
    end
  end

endmodule // flow_word_map

`default_nettype wire

// >>> src/modbus_flow_register_slave.v
// What this block does
// - Holding and input register reads return data; coil and discrete input reads get an address exception.
// - Single and multiple writes to registers and to coils are decoded and answered.
// - A multi-register write that starts or stops inside a value is refused and never applied.
// - Function codes 01 to 06, 08, 15, 16 and 17 are decoded.
// - Diagnostics accept subfunction 00 only and return the request unchanged.
// - Channel one rate, total and precise total read at 0x0000, 0x0002 and 0x0004.
// - Channel two rate, total and precise total read at 0x0008, 0x000a and 0x000c.
// - Quadrature rate, total and precise total read at 0x0010, 0x0012 and 0x0014.
`timescale 1ns/10ps
`default_nettype none
`include "modbus_slave_map.vh"

module modbus_flow_register_slave (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_last_i,
  output wire        rx_ready_o,
  output wire        tx_valid_o,
  output wire [7:0]  tx_data_o,
  output wire        tx_last_o,
  input  wire        tx_ready_i,
  input  wire [31:0] channel_one_rate_i,
  input  wire [31:0] channel_one_total_i,
  input  wire [63:0] channel_one_precise_total_i,
  input  wire [31:0] channel_two_rate_i,
  input  wire [31:0] channel_two_total_i,
  input  wire [63:0] channel_two_precise_total_i,
  input  wire [31:0] quadrature_rate_i,
  input  wire [31:0] quadrature_total_i,
  input  wire [63:0] quadrature_precise_total_i
);

  // Arbitrary slave identity byte returned by report slave id
  parameter [7:0] SLAVE_ID = 8'h5a;

  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_DECIDE = 3'd1;
  localparam [2:0] ST_HEAD   = 3'd2;
  localparam [2:0] ST_FETCH  = 3'd3;
  localparam [2:0] ST_HI     = 3'd4;
  localparam [2:0] ST_LO     = 3'd5;
  localparam [2:0] ST_ECHO   = 3'd6;

  localparam [1:0] BODY_NONE = 2'd0;
  localparam [1:0] BODY_REGS = 2'd1;
  localparam [1:0] BODY_ECHO = 2'd2;

  reg  [2:0]  state_reg;
  reg         rx_ready_reg;
  reg         tx_valid_reg;
  reg  [7:0]  tx_data_reg;
  reg         tx_last_reg;
  reg  [8:0]  len_reg;
  reg         overflow_reg;
  reg  [7:0]  fc_reg;
  reg  [15:0] addr_reg;
  reg  [15:0] qty_reg;
  reg  [7:0]  cnt_reg;
  reg  [7:0]  h0_reg;
  reg  [7:0]  h1_reg;
  reg  [7:0]  h2_reg;
  reg  [7:0]  h3_reg;
  reg  [2:0]  hcnt_reg;
  reg  [2:0]  hidx_reg;
  reg  [1:0]  body_reg;
  reg  [4:0]  waddr_reg;
  reg  [7:0]  wleft_reg;
  reg  [7:0]  ridx_reg;
  reg  [7:0]  d_exc;
  reg  [1:0]  d_body;
  reg  [7:0]  d_count;
  reg  [7:0]  h_sel;
  wire        rx_take;
  wire        tx_free;
  wire        snap;
  wire [7:0]  rd_data;
  wire [15:0] word;
  wire [16:0] span_end;
  wire [15:0] last_addr;
  wire [8:0]  multi_len;

  // Register count for the value starting at an address, zero if none starts there
  function [2:0] param_len;
    input [15:0] a;
    begin
      case (a)
        `OFS_ONE_RATE, `OFS_ONE_TOTAL,
        `OFS_TWO_RATE, `OFS_TWO_TOTAL,
        `OFS_QUAD_RATE, `OFS_QUAD_TOTAL: param_len = `FLOAT_WORDS;
        `OFS_ONE_PRECISE, `OFS_TWO_PRECISE,
        `OFS_QUAD_PRECISE: param_len = `DOUBLE_WORDS;
        default: param_len = 3'h0;
      endcase
    end
  endfunction

  // True when a register address is the final register in some value
  function is_end;
    input [15:0] e;
    begin
      is_end = (param_len(e - 16'h0001) == `FLOAT_WORDS) ||
               (param_len(e - 16'h0003) == `DOUBLE_WORDS);
    end
  endfunction

  assign rx_ready_o = rx_ready_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o  = tx_data_reg;
  assign tx_last_o  = tx_last_reg;
  assign rx_take    = rx_valid_i && rx_ready_reg;
  assign tx_free    = !tx_valid_reg || tx_ready_i;
  assign snap       = (state_reg == ST_DECIDE);
  assign span_end   = {1'b0, addr_reg} + {1'b0, qty_reg};
  assign last_addr  = addr_reg + qty_reg - 16'h0001;
  assign multi_len  = {1'b0, cnt_reg} + `LEN_MULTI_HEAD;

  // Whole request kept for the diagnostic echo
  pdu_buffer u_buffer (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .wr_en_i   (rx_take && !len_reg[8]), // Byte 257 on would wrap onto the first slot
    .wr_addr_i (len_reg[7:0]),
    .wr_data_i (rx_data_i),
    .rd_addr_i (ridx_reg),
    .rd_data_o (rd_data)
  );

  // Read-only value map, captured once per request
  flow_word_map u_map (
    .clock_i                     (clock_i),
    .rst_i                       (rst_i),
    .snap_i                      (snap),
    .channel_one_rate_i          (channel_one_rate_i),
    .channel_one_total_i         (channel_one_total_i),
    .channel_one_precise_total_i (channel_one_precise_total_i),
    .channel_two_rate_i          (channel_two_rate_i),
    .channel_two_total_i         (channel_two_total_i),
    .channel_two_precise_total_i (channel_two_precise_total_i),
    .quadrature_rate_i           (quadrature_rate_i),
    .quadrature_total_i          (quadrature_total_i),
    .quadrature_precise_total_i  (quadrature_precise_total_i),
    .addr_i                      (waddr_reg),
    .word_o                      (word)
  );

  // Request decode: exception code and answer body; checks run from
  // length to value to address so the most basic fault is reported
  always @* begin
    d_exc   = `EXC_NONE;
    d_body  = BODY_NONE;
    d_count = {qty_reg[6:0], 1'b0};
    if (overflow_reg) begin
      d_exc = `EXC_VALUE;
    end else begin
      case (fc_reg)
        `FC_READ_COILS, `FC_READ_DISCRETE: begin
          if (len_reg != `LEN_FIXED || qty_reg == 16'h0000 || qty_reg > `MAX_READ_BITS)
            d_exc = `EXC_VALUE;
          else
            d_exc = `EXC_ADDRESS; // No bit objects are mapped
        end
        `FC_WRITE_COIL: begin
          if (len_reg != `LEN_FIXED || (qty_reg != `COIL_ON && qty_reg != `COIL_OFF))
            d_exc = `EXC_VALUE;
          else
            d_exc = `EXC_ADDRESS;
        end
        `FC_WRITE_COILS: begin
          if (len_reg < `LEN_MULTI_HEAD || len_reg != multi_len || qty_reg == 16'h0000)
            d_exc = `EXC_VALUE;
          else
            d_exc = `EXC_ADDRESS;
        end
        `FC_READ_HOLDING, `FC_READ_INPUT: begin
          if (len_reg != `LEN_FIXED || qty_reg == 16'h0000 || qty_reg > `MAX_READ_REGS)
            d_exc = `EXC_VALUE;
          else if (span_end > `MAP_WORDS)
            d_exc = `EXC_ADDRESS;
          else
            d_body = BODY_REGS;
        end
        `FC_WRITE_REG: begin
          if (len_reg != `LEN_FIXED)
            d_exc = `EXC_VALUE;
          else if ({1'b0, addr_reg} >= `MAP_WORDS)
            d_exc = `EXC_ADDRESS;
          else
            d_exc = `EXC_READ_ONLY;
        end
        `FC_WRITE_REGS: begin
          if (len_reg < `LEN_MULTI_HEAD || len_reg != multi_len || qty_reg == 16'h0000 ||
              qty_reg > `MAX_WRITE_REGS || {8'h00, cnt_reg} != {qty_reg[14:0], 1'b0})
            d_exc = `EXC_VALUE;
          else if (span_end > `MAP_WORDS)
            d_exc = `EXC_ADDRESS;
          else if (param_len(addr_reg) == 3'h0 || !is_end(last_addr))
            d_exc = `EXC_ADDRESS; // Misaligned, nothing applied
          else
            d_exc = `EXC_READ_ONLY;
        end
        `FC_DIAG: begin
          if (len_reg < `LEN_DIAG_MIN)
            d_exc = `EXC_VALUE;
          else if (addr_reg != `DIAG_SUB_ECHO)
            d_exc = `EXC_FUNCTION;
          else
            d_body = BODY_ECHO;
        end
        `FC_REPORT_ID: begin
          if (len_reg != `LEN_REPORT_ID)
            d_exc = `EXC_VALUE;
        end
        default: d_exc = `EXC_FUNCTION;
      endcase
    end
  end

  // Header byte chosen by index
  always @* begin
    case (hidx_reg)
      3'd0: h_sel = h0_reg;
      3'd1: h_sel = h1_reg;
      3'd2: h_sel = h2_reg;
      default: h_sel = h3_reg;
    endcase
  end

  // Main sequencer: receive, decide, then stream the answer
  always @(posedge clock_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      rx_ready_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      tx_last_reg  <= 1'b0;
      len_reg      <= 9'h000;
      overflow_reg <= 1'b0;
      fc_reg       <= 8'h00;
      addr_reg     <= 16'h0000;
      qty_reg      <= 16'h0000;
      cnt_reg      <= 8'h00;
      h0_reg       <= 8'h00;
      h1_reg       <= 8'h00;
      h2_reg       <= 8'h00;
      h3_reg       <= 8'h00;
      hcnt_reg     <= 3'd0;
      hidx_reg     <= 3'd0;
      body_reg     <= BODY_NONE;
      waddr_reg    <= 5'd0;
      wleft_reg    <= 8'h00;
      ridx_reg     <= 8'h00;
    end else begin
      // A taken byte leaves the output register
      if (tx_valid_reg && tx_ready_i) begin
        tx_valid_reg <= 1'b0;
        tx_last_reg  <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          rx_ready_reg <= 1'b1;
          if (rx_take) begin
            case (len_reg)
              9'd0: fc_reg <= rx_data_i;
              9'd1: addr_reg[15:8] <= rx_data_i;
              9'd2: addr_reg[7:0] <= rx_data_i;
              9'd3: qty_reg[15:8] <= rx_data_i;
              9'd4: qty_reg[7:0] <= rx_data_i;
              9'd5: cnt_reg <= rx_data_i;
              default: cnt_reg <= cnt_reg;
            endcase
            // Bytes past the buffer are dropped and flagged
            if (len_reg == `LEN_LIMIT)
              overflow_reg <= 1'b1;
            else
              len_reg <= len_reg + 9'h001;
            if (rx_last_i) begin
              rx_ready_reg <= 1'b0;
              state_reg    <= ST_DECIDE;
            end
          end
        end
        ST_DECIDE: begin
          // Decode has already used the flag, so the next request starts clean
          overflow_reg <= 1'b0;
          hidx_reg <= 3'd0;
          ridx_reg <= 8'h00;
          waddr_reg <= addr_reg[4:0];
          wleft_reg <= qty_reg[7:0];
          h0_reg   <= fc_reg;
          if (d_exc != `EXC_NONE) begin
            h0_reg   <= fc_reg | `EXC_FLAG;
            h1_reg   <= d_exc;
            hcnt_reg <= 3'd2;
            body_reg <= BODY_NONE;
          end else if (d_body == BODY_ECHO) begin
            hcnt_reg <= 3'd0;
            body_reg <= BODY_ECHO;
          end else if (d_body == BODY_REGS) begin
            h1_reg   <= d_count;
            hcnt_reg <= 3'd2;
            body_reg <= BODY_REGS;
          end else begin
            h1_reg   <= `ID_BYTE_COUNT;
            h2_reg   <= SLAVE_ID;
            h3_reg   <= `RUN_ON;
            hcnt_reg <= 3'd4;
            body_reg <= BODY_NONE;
          end
          state_reg <= (d_body == BODY_ECHO && d_exc == `EXC_NONE) ? ST_FETCH : ST_HEAD;
        end
        ST_HEAD: begin
          if (tx_free) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= h_sel;
            tx_last_reg  <= (hidx_reg == hcnt_reg - 3'd1) && (body_reg == BODY_NONE);
            hidx_reg     <= hidx_reg + 3'd1;
            if (hidx_reg == hcnt_reg - 3'd1)
              state_reg <= (body_reg == BODY_NONE) ? ST_IDLE : ST_FETCH;
            if (hidx_reg == hcnt_reg - 3'd1 && body_reg == BODY_NONE)
              len_reg <= 9'h000;
          end
        end
        ST_FETCH: begin
          // One cycle for the registered map or buffer read
          state_reg <= (body_reg == BODY_ECHO) ? ST_ECHO : ST_HI;
        end
        ST_HI: begin
          if (tx_free) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= word[15:8];
            state_reg    <= ST_LO;
          end
        end
        ST_LO: begin
          if (tx_free) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= word[7:0];
            tx_last_reg  <= (wleft_reg == 8'h01);
            wleft_reg    <= wleft_reg - 8'h01;
            waddr_reg    <= waddr_reg + 5'd1;
            state_reg    <= (wleft_reg == 8'h01) ? ST_IDLE : ST_FETCH;
            if (wleft_reg == 8'h01)
              len_reg <= 9'h000;
          end
        end
        ST_ECHO: begin
          if (tx_free) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= rd_data; // Query data returned unchanged
            tx_last_reg  <= ({1'b0, ridx_reg} == len_reg - 9'h001);
            ridx_reg     <= ridx_reg + 8'h01;
            state_reg    <= ({1'b0, ridx_reg} == len_reg - 9'h001) ? ST_IDLE : ST_FETCH;
            if ({1'b0, ridx_reg} == len_reg - 9'h001)
              len_reg <= 9'h000;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // modbus_flow_register_slave

`default_nettype wire

// >>> test/modbus_flow_register_slave_checker.sv
`timescale 1ns/10ps
`default_nettype none

module modbus_flow_register_slave_checker (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic       rx_last_i,
  input wire logic       rx_ready_o,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_last_o,
  input wire logic       tx_ready_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic       rx_first_reg;
  logic       tx_first_reg;
  logic [7:0] fc_reg;
  logic       rx_take;
  logic       tx_take;
  logic       fc_known;

  // Handshake strobes, and whether the latched function code is one we decode
  assign rx_take  = rx_valid_i && rx_ready_o;
  assign tx_take  = tx_valid_o && tx_ready_i;
  assign fc_known = fc_reg inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0f,
                                   8'h10, 8'h11};

  // Message boundaries; the code is latched from each request's first byte
  always @(posedge clock_i) begin
    if (rst_i) begin
      rx_first_reg <= 1'b1;
      tx_first_reg <= 1'b1;
      fc_reg       <= 8'h00;
    end else begin
      if (rx_take) rx_first_reg <= rx_last_i;
      if (rx_take && rx_first_reg) fc_reg <= rx_data_i;
      if (tx_take) tx_first_reg <= tx_last_o;
    end
  end

  sequence req_end;
    rx_take && rx_last_i;
  endsequence

  sequence exc_head;
    tx_take && tx_first_reg && tx_data_o[7];
  endsequence

  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o)) else $error("answer byte changed before taken");
  ready_drop_a: assert property (req_end |=> !rx_ready_o) else $error("request port stayed ready");
  answer_due_a: assert property (req_end |-> ##[2:40] tx_valid_o) else $error("no answer started");
  fc_echo_a: assert property (tx_valid_o && tx_first_reg |-> tx_data_o[6:0] == fc_reg[6:0]) else $error("answer code differs");
  unsup_fc_a: assert property (tx_valid_o && tx_first_reg && !fc_known |-> tx_data_o == (fc_reg | 8'h80)) else $error("unknown code not refused");
  exc_pair_a: assert property (exc_head |-> ##[1:8] (tx_valid_o && tx_last_o && tx_data_o inside {[8'h01:8'h04]})) else $error("bad exception tail");
  first_last_a: assert property (tx_valid_o && tx_first_reg |-> !tx_last_o) else $error("one byte answer");
  ready_back_a: assert property (tx_take && tx_last_o |-> ##[0:2] rx_ready_o) else $error("request port not reopened");
endmodule // modbus_flow_register_slave_checker

bind modbus_flow_register_slave modbus_flow_register_slave_checker u_checker (
  .clock_i(clock_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
  .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i));

`default_nettype wire

// >>> test/modbus_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module modbus_master_model (
  input  wire logic       clock_i,
  output var  logic       req_valid_o,
  output var  logic [7:0] req_data_o,
  output var  logic       req_last_o,
  input  wire logic       req_ready_i,
  input  wire logic       ans_valid_i,
  input  wire logic [7:0] ans_data_i,
  input  wire logic       ans_last_i,
  output var  logic       ans_ready_o
);
  // Idle link at time zero
  initial begin
    req_valid_o = 1'b0;
    req_data_o  = 8'h00;
    req_last_o  = 1'b0;
    ans_ready_o = 1'b0;
  end

  // One request, then its answer; stall > 0 takes answer bytes only every stall+1 cycles
  task automatic xfer(input logic [7:0] req[$], input int stall, output logic [7:0] ans[$]);
    int k;
    ans.delete();
    foreach (req[i]) begin
      req_valid_o <= 1'b1;
      req_data_o  <= req[i];
      req_last_o  <= (i == req.size() - 1);
      do @(posedge clock_i); while (req_ready_i !== 1'b1);
    end
    // Released data line toggles so a stale byte cannot pass for a good one
    req_valid_o <= 1'b0;
    req_last_o  <= 1'b0;
    req_data_o  <= ~req_data_o;
    ans_ready_o <= (stall == 0);
    k = 0;
    forever begin
      @(posedge clock_i);
      if (ans_valid_i === 1'b1 && ans_ready_o) begin
        ans.push_back(ans_data_i);
        if (ans_last_i === 1'b1) break;
      end
      k++;
      ans_ready_o <= (k % (stall + 1)) == 0;
    end
    ans_ready_o <= 1'b0;
  endtask
endmodule // modbus_master_model

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic         clock_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0]   rx_data, tx_data;
  logic [31:0]  c1r = 32'h3f80_1234, c1t = 32'h4120_5678, c2r = 32'hc2a0_0001;
  logic [31:0]  c2t = 32'h4480_beef, qr = 32'h4000_cafe, qt = 32'h4700_0102;
  logic [63:0]  c1p = 64'h4059_0000_1111_2222, c2p = 64'hc08f_3333_4444_5555;
  logic [63:0]  qp = 64'h40c3_6666_7777_8888;
  logic [383:0] map;
  int           miscompares = 0;
  int           checks_done = 0;
  int           cycle_count = 0;

  assign map = {c1r, c1t, c1p, c2r, c2t, c2p, qr, qt, qp};

  // 40 MHz clock
  always #12.5 clock_i = ~clock_i;

  modbus_flow_register_slave u_modbus_flow_register_slave (
    .clock_i(clock_i), .rst_i(rst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_last_i(rx_last), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_last_o(tx_last), .tx_ready_i(tx_ready), .channel_one_rate_i(c1r),
    .channel_one_total_i(c1t), .channel_one_precise_total_i(c1p), .channel_two_rate_i(c2r),
    .channel_two_total_i(c2t), .channel_two_precise_total_i(c2p), .quadrature_rate_i(qr),
    .quadrature_total_i(qt), .quadrature_precise_total_i(qp));

  modbus_master_model u_master (
    .clock_i(clock_i), .req_valid_o(rx_valid), .req_data_o(rx_data), .req_last_o(rx_last),
    .req_ready_i(rx_ready), .ans_valid_i(tx_valid), .ans_data_i(tx_data),
    .ans_last_i(tx_last), .ans_ready_o(tx_ready));

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Whole answer compared byte by byte, a short answer shows as unknown bytes
  task automatic expect_ans(input string what, input logic [7:0] got[$], input logic [7:0] exp[$]);
    check({what, " length"}, 8'(got.size()), 8'(exp.size()));
    foreach (exp[i]) check(what, (i < got.size()) ? got[i] : 8'hxx, exp[i]);
  endtask

  task automatic read_check(input logic [7:0] fc, input int addr, input int qty, input int stall);
    logic [7:0] ans[$];
    logic [7:0] exp[$];
    exp = '{fc, 8'(2 * qty)};
    for (int i = 0; i < 2 * qty; i++) exp.push_back(map[383 - 8 * (2 * addr + i) -: 8]);
    u_master.xfer('{fc, 8'h00, 8'(addr), 8'h00, 8'(qty)}, stall, ans);
    expect_ans("register read", ans, exp);
  endtask

  // Whole-map and single-value reads, with the master stalling
  task automatic t_reads;
    read_check(8'h03, 0, 24, 0);
    read_check(8'h04, 12, 4, 2);
    read_check(8'h03, 16, 2, 1);
    read_check(8'h04, 4, 4, 0);
    $display("test reads done");
  endtask

  task automatic exc(input logic [7:0] req[$], input logic [7:0] code);
    logic [7:0] ans[$];
    u_master.xfer(req, 0, ans);
    expect_ans("exception", ans, '{req[0] | 8'h80, code});
  endtask

  // Writes to the read-only map, misaligned writes and refused codes
  task automatic t_exceptions;
    logic [7:0] big[$];
    exc('{8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h02);
    exc('{8'h02, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h02);
    exc('{8'h05, 8'h00, 8'h00, 8'hff, 8'h00}, 8'h02);
    exc('{8'h06, 8'h00, 8'h02, 8'h12, 8'h34}, 8'h04);
    exc('{8'h0f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01}, 8'h02);
    exc('{8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h04);
    exc('{8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h02);
    exc('{8'h10, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h02);
    exc('{8'h03, 8'h00, 8'h16, 8'h00, 8'h04}, 8'h02);
    exc('{8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h03);
    exc('{8'h08, 8'h00, 8'h01, 8'h00, 8'h00}, 8'h01);
    exc('{8'h07}, 8'h01);
    // Oversized request is refused; the read after it shows the flag was cleared
    for (int i = 0; i < 258; i++) big.push_back(8'h10);
    exc(big, 8'h03);
    read_check(8'h03, 10, 2, 0);
    $display("test exceptions done");
  endtask

  // Diagnostic echo and identity report
  task automatic t_diag_report;
    logic [7:0] ans[$];
    u_master.xfer('{8'h08, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'h3c}, 1, ans);
    expect_ans("diagnostic echo", ans, '{8'h08, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'h3c});
    u_master.xfer('{8'h11}, 0, ans);
    expect_ans("identity report", ans, '{8'h11, 8'h02, 8'h5a, 8'hff});
    $display("test diag_report done");
  endtask

  // Hang guard well above the several hundred cycles the tests need
  always @(posedge clock_i) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    t_reads();
    t_exceptions();
    t_diag_report();
    wrap_up();
  end
endmodule // tb

`default_nettype wire
